// File: dmct_pkg.sv
// constants for the dual mode compare timer: register map, field positions,
// reset values, clock select codes and power mode codes.
// assumes an axi4-lite master with 32-bit data; only byte lane 0 carries data.
package dmct_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CTRL_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CNT_HIGH = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CNT_LOW = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_CMP_HIGH = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_CMP_LOW = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_EDGE_IRQ = 8'h18;

	// counter_control_reg fields
	localparam int CTRL_HIGH_LEVEL = 7;
	localparam int CTRL_HIGH_SEL_LSB = 4;
	localparam int CTRL_LOW_LEVEL = 3;
	localparam int CTRL_LOW_SEL_LSB = 0;
	localparam int SEL_TOP = 2;

	// counter_ctrl_status_reg fields
	localparam int CSR_OVF_HIGH = 7;
	localparam int CSR_MATCH_HIGH = 6;
	localparam int CSR_OVIE_HIGH = 5;
	localparam int CSR_CLR_HIGH = 4;
	localparam int CSR_OVF_LOW = 3;
	localparam int CSR_MATCH_LOW = 2;
	localparam int CSR_OVIE_LOW = 1;
	localparam int CSR_CLR_LOW = 0;
	localparam logic [7:0] CSR_FLAG_MASK = 8'hCC;

	// edge select and irq enable register fields
	localparam int AUX_EDGE = 0;
	localparam int AUX_IRQ_HIGH = 1;
	localparam int AUX_IRQ_LOW = 2;

	// reset values
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CMP_RST = 16'hFFFF;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CSR_RST = 8'h00;
	localparam logic [2:0] AUX_RST = 3'h0;

	// internal clock selection, low two bits of a select field
	localparam int PRE_W = 5;
	localparam logic [1:0] CKS_DIV32 = 2'h0;
	localparam logic [1:0] CKS_DIV16 = 2'h1;
	localparam logic [1:0] CKS_DIV4 = 2'h2;
	localparam logic [1:0] CKS_DIV2 = 2'h3;

	// power modes
	localparam logic [2:0] PM_ACTIVE = 3'h0;
	localparam logic [2:0] PM_SLEEP = 3'h1;
	localparam logic [2:0] PM_WATCH = 3'h2;
	localparam logic [2:0] PM_SUBACTIVE = 3'h3;
	localparam logic [2:0] PM_SUBSLEEP = 3'h4;
	localparam logic [2:0] PM_STANDBY = 3'h5;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: dmct_timer.sv
// dual mode compare timer: one 16-bit or two 8-bit counters with compare,
// toggling outputs, match and overflow flags, behind an axi4-lite slave.
// assumes event_count_input and power_mode are synchronous to aclk.
//
// Contract
// - high clock select top 0: one 16-bit counter; 1: two 8-bit counters
// - reset: counter 0x0000, compare 0xFFFF, control and status 0x00
// - counter advances one per pulse of the selected clock
// - internal clocks are system clock divided by 32, 16, 4 or 2
// - low select top 0 counts event input, edge chosen by edge select
// - compare pins drive written level and invert on each match
// - match clear bit set clears counter or half on match
// - 16-bit mode: high overflow flag on 0xFFFF to 0x0000
// - match signal issued as counter leaves the matching value
// - counter runs in active and sleep, halts in other modes
// - register writes land only in active mode, are dropped otherwise
// - 16-bit: high pin toggles on full match; control write wins
// - low compare write suppresses a coincident match
// - low match only on a low counter clock pulse
// - 16-bit: high flag on full match, low flag on low byte match
// - 16-bit: low overflow flag on low byte rollover too
// - counter byte write suppresses that byte's coincident overflow
// - 8-bit: each pin toggles on its half; control write wins
// - 8-bit: high compare write suppresses match; high clock paced
// - overflow flag with both enables raises the interrupt request
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps

module dmct_timer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [dmct_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [dmct_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [dmct_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [dmct_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic event_count_input,
	input wire logic [2:0] power_mode,
	output logic compare_out_high,
	output logic compare_out_low,
	output logic timer_irq
);
	import dmct_pkg::*;

	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [DATA_W-1:0] rdata_q;
	logic aw_held_q, w_held_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wlane_q;
	logic [7:0] counter_control_reg_q, counter_ctrl_status_reg_q;
	logic [2:0] edge_irq_reg_q;
	logic [15:0] main_counter_q, compare_value_q;
	logic [7:0] temp_q;
	logic [PRE_W-1:0] prescale_q;
	logic event_prev_q;
	logic out_high_q, out_low_q, irq_q;

	logic do_write, active, running, wr_ok, split_mode;
	logic wr_ctrl, wr_csr, wr_cnt_h, wr_cnt_l, wr_cmp_h, wr_cmp_l, wr_aux;
	logic ext_pulse, tick_l, tick_h;
	logic [7:0] counter_high_byte, counter_low_byte, compare_high_byte, compare_low_byte;
	logic eq_low, eq_high, eq_full;
	logic match_l, match_h, ovf_l, ovf_h;
	logic rd_take, rd_hit;
	logic [7:0] rd_byte;

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign compare_out_high = out_high_q;
	assign compare_out_low = out_low_q;
	assign timer_irq = irq_q;

	assign counter_high_byte = main_counter_q[15:8];
	assign counter_low_byte = main_counter_q[7:0];
	assign compare_high_byte = compare_value_q[15:8];
	assign compare_low_byte = compare_value_q[7:0];

	assign split_mode = counter_control_reg_q[CTRL_HIGH_SEL_LSB + SEL_TOP];

	assign active = (power_mode == PM_ACTIVE);
	assign running = active || (power_mode == PM_SLEEP);

	// write side of the bus: address and data are taken in either order
	assign do_write = aw_held_q && w_held_q && !bvalid_q;
	// writes land only in active mode
	assign wr_ok = do_write && wlane_q && active;
	assign wr_ctrl = wr_ok && (awaddr_q == OFF_CONTROL);
	assign wr_csr = wr_ok && (awaddr_q == OFF_CTRL_STATUS);
	assign wr_cnt_h = wr_ok && (awaddr_q == OFF_CNT_HIGH);
	assign wr_cnt_l = wr_ok && (awaddr_q == OFF_CNT_LOW);
	assign wr_cmp_h = wr_ok && (awaddr_q == OFF_CMP_HIGH);
	assign wr_cmp_l = wr_ok && (awaddr_q == OFF_CMP_LOW);
	assign wr_aux = wr_ok && (awaddr_q == OFF_EDGE_IRQ);

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		addr_mapped = (a == OFF_CONTROL) || (a == OFF_CTRL_STATUS) || (a == OFF_CNT_HIGH)
			|| (a == OFF_CNT_LOW) || (a == OFF_CMP_HIGH) || (a == OFF_CMP_LOW)
			|| (a == OFF_EDGE_IRQ);
	endfunction

	// one prescaler serves both halves so their ticks stay phase locked
	function automatic logic int_tick(input logic [1:0] sel, input logic [PRE_W-1:0] pre);
		int_tick = 1'b0;
		unique case (sel)
			CKS_DIV32: int_tick = &pre[4:0];
			CKS_DIV16: int_tick = &pre[3:0];
			CKS_DIV4: int_tick = &pre[1:0];
			CKS_DIV2: int_tick = pre[0];
		endcase
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prescale_q <= '0;
			event_prev_q <= 1'b0;
		end else begin
			prescale_q <= prescale_q + 1'b1;
			event_prev_q <= event_count_input;
		end
	end

	// event edge detect; narrower pulses can be missed
	assign ext_pulse = edge_irq_reg_q[AUX_EDGE] ? (!event_count_input && event_prev_q)
		: (event_count_input && !event_prev_q);

	assign tick_l = running && (counter_control_reg_q[CTRL_LOW_SEL_LSB + SEL_TOP]
		? int_tick(counter_control_reg_q[CTRL_LOW_SEL_LSB +: 2], prescale_q) : ext_pulse);
	assign tick_h = running && split_mode
		&& int_tick(counter_control_reg_q[CTRL_HIGH_SEL_LSB +: 2], prescale_q);

	assign eq_low = (counter_low_byte == compare_low_byte);
	assign eq_high = (counter_high_byte == compare_high_byte);
	assign eq_full = eq_low && eq_high;

	// match fires on the clock pulse that leaves the equal value
	// low match paced by the low clock; compare write inhibits
	assign match_l = tick_l && eq_low && !wr_cmp_l;
	// high match paced by its own clock in split mode
	assign match_h = split_mode ? (tick_h && eq_high && !wr_cmp_h)
		: (tick_l && eq_full && !wr_cmp_l);

	// a coincident counter byte write hides the overflow
	assign ovf_l = tick_l && (counter_low_byte == 8'hFF) && !wr_cnt_l
		&& !(match_l && counter_ctrl_status_reg_q[CSR_CLR_LOW] && split_mode);
	assign ovf_h = split_mode
		? (tick_h && (counter_high_byte == 8'hFF) && !wr_cnt_h
			&& !(match_h && counter_ctrl_status_reg_q[CSR_CLR_HIGH]))
		: (tick_l && (main_counter_q == 16'hFFFF) && !wr_cnt_l
			&& !(match_h && counter_ctrl_status_reg_q[CSR_CLR_HIGH]));

	// counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			main_counter_q <= CNT_RST;
		end else if (!split_mode) begin
			if (wr_cnt_l) begin
				main_counter_q <= {temp_q, wdata_q};
			end else if (tick_l) begin
				if (match_h && counter_ctrl_status_reg_q[CSR_CLR_HIGH]) begin
					main_counter_q <= CNT_RST;
				end else begin
					// carry from low byte into high byte
					main_counter_q <= main_counter_q + 16'h0001;
				end
			end
		end else begin
			if (wr_cnt_l) begin
				main_counter_q[7:0] <= wdata_q;
			end else if (tick_l) begin
				main_counter_q[7:0] <= (match_l && counter_ctrl_status_reg_q[CSR_CLR_LOW])
					? CNT_RST[7:0] : counter_low_byte + 8'h01;
			end
			if (wr_cnt_h) begin
				main_counter_q[15:8] <= wdata_q;
			end else if (tick_h) begin
				main_counter_q[15:8] <= (match_h && counter_ctrl_status_reg_q[CSR_CLR_HIGH])
					? CNT_RST[15:8] : counter_high_byte + 8'h01;
			end
		end
	end

	// compare value; in 16-bit mode the high byte waits in temp until the low write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			compare_value_q <= CMP_RST;
		end else if (wr_cmp_l) begin
			compare_value_q <= split_mode ? {compare_high_byte, wdata_q} : {temp_q, wdata_q};
		end else if (wr_cmp_h && split_mode) begin
			compare_value_q[15:8] <= wdata_q;
		end
	end

	// temp byte: upper write parks data, upper counter read snapshots lower byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			temp_q <= 8'h00;
		end else if ((wr_cnt_h || wr_cmp_h) && !split_mode) begin
			temp_q <= wdata_q;
		end else if (rd_take && (s_axi_araddr == OFF_CNT_HIGH) && !split_mode) begin
			temp_q <= counter_low_byte;
		end
	end

	// control, edge and irq enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter_control_reg_q <= CTRL_RST;
			edge_irq_reg_q <= AUX_RST;
		end else begin
			if (wr_ctrl) begin
				counter_control_reg_q <= wdata_q;
			end
			if (wr_aux) begin
				edge_irq_reg_q <= wdata_q[2:0];
			end
		end
	end

	// status: hardware set wins over a software clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter_ctrl_status_reg_q <= CSR_RST;
		end else begin
			if (wr_csr) begin
				counter_ctrl_status_reg_q <= (wdata_q & ~CSR_FLAG_MASK)
					| (wdata_q & counter_ctrl_status_reg_q & CSR_FLAG_MASK);
			end
			// full match (high byte match in 8-bit mode) sets high flag, low byte match sets low flag
			if (match_h) begin
				counter_ctrl_status_reg_q[CSR_MATCH_HIGH] <= 1'b1;
			end
			if (match_l) begin
				counter_ctrl_status_reg_q[CSR_MATCH_LOW] <= 1'b1;
			end
			if (ovf_h) begin
				counter_ctrl_status_reg_q[CSR_OVF_HIGH] <= 1'b1;
			end
			// low rollover flagged in both modes
			if (ovf_l) begin
				counter_ctrl_status_reg_q[CSR_OVF_LOW] <= 1'b1;
			end
		end
	end

	// compare pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_high_q <= 1'b0;
			out_low_q <= 1'b0;
		end else begin
			// written level beats a coincident toggle
			if (wr_ctrl) begin
				out_high_q <= wdata_q[CTRL_HIGH_LEVEL];
			end else if (match_h) begin
				out_high_q <= !out_high_q;
			end
			// low pin still follows low byte matches in 16-bit mode
			if (wr_ctrl) begin
				out_low_q <= wdata_q[CTRL_LOW_LEVEL];
			end else if (match_l) begin
				out_low_q <= !out_low_q;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (edge_irq_reg_q[AUX_IRQ_HIGH] && (counter_ctrl_status_reg_q[CSR_MATCH_HIGH]
				|| (counter_ctrl_status_reg_q[CSR_OVF_HIGH]
					&& counter_ctrl_status_reg_q[CSR_OVIE_HIGH])))
				|| (edge_irq_reg_q[AUX_IRQ_LOW] && (counter_ctrl_status_reg_q[CSR_MATCH_LOW]
				|| (counter_ctrl_status_reg_q[CSR_OVF_LOW]
					&& counter_ctrl_status_reg_q[CSR_OVIE_LOW])));
		end
	end

	// write channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 8'h00;
			wlane_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && awready_q) begin
				awready_q <= 1'b0;
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_q) begin
				wready_q <= 1'b0;
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata[7:0];
				wlane_q <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= addr_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// read channels
	assign rd_take = s_axi_arvalid && arready_q;
	assign rd_hit = addr_mapped(s_axi_araddr);

	always_comb begin
		rd_byte = 8'h00;
		unique case (s_axi_araddr)
			OFF_CONTROL: rd_byte = counter_control_reg_q;
			OFF_CTRL_STATUS: rd_byte = counter_ctrl_status_reg_q;
			OFF_CNT_HIGH: rd_byte = counter_high_byte;
			OFF_CNT_LOW: rd_byte = split_mode ? counter_low_byte : temp_q;
			OFF_CMP_HIGH: rd_byte = compare_high_byte;
			OFF_CMP_LOW: rd_byte = compare_low_byte;
			OFF_EDGE_IRQ: rd_byte = {5'h00, edge_irq_reg_q};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else begin
			if (rd_take) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= {24'h000000, rd_byte};
				rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

endmodule

// File: dmct_sva.sv
// checker for dmct_timer: bus handshakes, response codes, pins while halted.
// assumes it is bound to dmct_timer and sees only that module's ports.
`timescale 1ns/100ps
module dmct_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [dmct_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [dmct_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] power_mode,
	input wire logic compare_out_high,
	input wire logic compare_out_low
);
	import dmct_pkg::*;
	logic [ADDR_W-1:0] waddr_q;
	logic mapped;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) begin
			waddr_q <= s_axi_awaddr;
		end
	end
	assign mapped = (waddr_q <= OFF_EDGE_IRQ) && (waddr_q[1:0] == 2'h0);
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
	a_write_resp: assert property (s_axi_bvalid
		|-> s_axi_bresp == (mapped ? RESP_OKAY : RESP_SLVERR)) else $error("bad bresp");
	a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read not answered");
	a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	a_read_clear: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid && s_axi_arready) else $error("read answer not retired");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	// halted modes neither count nor take writes, so pins stand still
	a_halt_pins: assert property (
		$past(power_mode) >= PM_WATCH && $past(power_mode, 2) >= PM_WATCH
		|-> $stable(compare_out_high) && $stable(compare_out_low))
		else $error("compare pin moved while halted");
endmodule

// File: dmct_evsrc.sv
// model of the external event source feeding event_count_input.
// assumes the bench holds npulse and width steady while busy.
`timescale 1ns/100ps
module dmct_evsrc (
	input wire logic aclk,
	input wire logic start,
	input wire logic [7:0] npulse,
	input wire logic [3:0] width,
	output logic ev,
	output logic busy
);
	logic [7:0] left;
	logic [3:0] cnt;
	initial begin
		ev = 1'b0;
		busy = 1'b0;
	end
	// each level held width cycles, a single cycle when width is below two
	always @(posedge aclk) begin
		if (start && !busy) begin
			busy <= 1'b1;
			left <= npulse;
			cnt <= width;
		end else if (busy && cnt > 4'h1) begin
			cnt <= cnt - 4'h1;
		end else if (busy) begin
			cnt <= width;
			if (ev) begin
				ev <= 1'b0;
				left <= left - 8'h01;
			end else if (left == 8'h00) begin
				busy <= 1'b0;
			end else begin
				ev <= 1'b1;
			end
		end
	end
endmodule

// File: tb.sv
// self-checking bench for dmct_timer over axi4-lite with an event source model.
// assumes bready and rready may stay high; reads are checked against a range.
`timescale 1ns/100ps
module tb;
	import dmct_pkg::*;
	logic aclk, aresetn, awready, wready, bvalid, arready, rvalid, ev, ev_busy, pin_h, pin_l, irq;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, ev_start = 1'b0;
	logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
	logic [DATA_W-1:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	logic [2:0] pmode = PM_ACTIVE;
	logic [7:0] ev_n = 8'h00;
	logic [3:0] ev_w = 4'h2;
	logic [17:0] rq[$];
	logic [1:0] wq[$];
	logic [7:0] offs[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	logic [7:0] rstv[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
	int divs[4] = '{32, 16, 4, 2};
	int mismatches = 0, samples_checked = 0, seed = 29621, k;
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	dmct_timer dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1), .event_count_input(ev), .power_mode(pmode),
		.compare_out_high(pin_h), .compare_out_low(pin_l), .timer_irq(irq));
	dmct_evsrc ev_u (.aclk(aclk), .start(ev_start), .npulse(ev_n), .width(ev_w),
		.ev(ev), .busy(ev_busy));
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic miss(input string nm, input logic [17:0] x, input logic [17:0] y);
		mismatches++;
		$display("mismatch %s expected %h seen %h", nm, x, y);
	endtask
	task automatic hang();
		miss("handshake", 18'h1, 18'h0);
		close_out();
	endtask
	task automatic cmp_resp(input logic [1:0] x, input logic [1:0] y);
		samples_checked++;
		if (x !== y) miss("bresp", x, y);
	endtask
	// expected read is {resp, low bound, high bound}
	task automatic cmp_read(input logic [17:0] x, input logic [1:0] r, input logic [7:0] d);
		samples_checked++;
		if (r !== x[17:16] || ((d >= x[15:8]) && (d <= x[7:0])) !== 1'b1) miss("rdata", x, {r, d, d});
	endtask
	task automatic cmp_pin(input string nm, input logic x, input logic y);
		samples_checked++;
		if (x !== y) miss(nm, x, y);
	endtask
	always @(posedge aclk) begin
		if (bvalid) cmp_resp(wq.pop_front(), bresp);
		if (rvalid) cmp_read(rq.pop_front(), rresp, rdata[7:0]);
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
		int n;
		wq.push_back(r);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// each channel is let go at its own handshake edge, in whichever order it comes
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (bvalid) break;
			if (awready && awvalid) awvalid <= 1'b0;
			if (wready && wvalid) wvalid <= 1'b0;
		end
		if (n == 50) hang();
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi,
		input logic [1:0] r = RESP_OKAY);
		int n;
		rq.push_back({r, lo, hi});
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (rvalid) break;
			if (arready && arvalid) arvalid <= 1'b0;
		end
		if (n == 50) hang();
	endtask
	task automatic pulses(input int c);
		int n;
		ev_n <= 8'(c);
		ev_w <= 4'(2 + {$random(seed)} % 4);
		ev_start <= 1'b1;
		@(posedge aclk);
		ev_start <= 1'b0;
		for (n = 0; n < 900; n++) begin
			@(posedge aclk);
			if (!ev_busy) break;
		end
		if (n == 900) hang();
	endtask
	initial begin
		aresetn = 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 7; i++) rd(offs[i], rstv[i], rstv[i]);
		rd(8'h1C, 8'h00, 8'hFF, RESP_SLVERR);
		wr(8'h1C, 8'hFF, RESP_SLVERR);
		$display("test reset done");
		k = 2 + {$random(seed)} % 5;
		pulses(k - 1);
		wr(OFF_EDGE_IRQ, 8'h01);
		pulses(1);
		pmode <= PM_WATCH;
		pulses(3);
		pmode <= PM_SLEEP;
		pulses(2);
		wr(OFF_CONTROL, 8'h80);
		pmode <= PM_ACTIVE;
		rd(OFF_CNT_HIGH, 8'h00, 8'h00);
		rd(OFF_CNT_LOW, 8'(k + 2), 8'(k + 2));
		rd(OFF_CONTROL, 8'h00, 8'h00);
		$display("test event count done");
		wr(OFF_CNT_HIGH, 8'h00);
		wr(OFF_CNT_LOW, 8'hFF);
		pulses(1);
		rd(OFF_CNT_HIGH, 8'h01, 8'h01);
		rd(OFF_CNT_LOW, 8'h00, 8'h00);
		rd(OFF_CTRL_STATUS, 8'h0C, 8'h0C);
		wr(OFF_CTRL_STATUS, 8'h00);
		wr(OFF_CNT_HIGH, 8'hFF);
		wr(OFF_CNT_LOW, 8'hFF);
		pulses(1);
		rd(OFF_CNT_HIGH, 8'h00, 8'h00);
		rd(OFF_CTRL_STATUS, 8'hCC, 8'hCC);
		// low pin is left unchecked while in 16-bit mode
		@(negedge aclk);
		cmp_pin("compare_out_high", 1'b1, pin_h);
		@(posedge aclk);
		$display("test overflow done");
		wr(OFF_CTRL_STATUS, 8'h01);
		wr(OFF_CONTROL, 8'h40);
		wr(OFF_CMP_LOW, 8'h03);
		pulses(3);
		rd(OFF_CNT_LOW, 8'h03, 8'h03);
		rd(OFF_CTRL_STATUS, 8'h01, 8'h01);
		pulses(1);
		rd(OFF_CNT_LOW, 8'h00, 8'h00);
		rd(OFF_CTRL_STATUS, 8'h05, 8'h05);
		wr(OFF_EDGE_IRQ, 8'h05);
		@(negedge aclk);
		cmp_pin("compare_out_low", 1'b1, pin_l);
		cmp_pin("timer_irq", 1'b1, irq);
		@(posedge aclk);
		wr(OFF_CTRL_STATUS, 8'h01);
		wr(OFF_CONTROL, 8'hC0);
		@(negedge aclk);
		cmp_pin("timer_irq", 1'b0, irq);
		cmp_pin("compare_out_high", 1'b1, pin_h);
		cmp_pin("compare_out_low", 1'b0, pin_l);
		@(posedge aclk);
		$display("test compare done");
		wr(OFF_CTRL_STATUS, 8'h00);
		// window between the two control writes is 323 cycles, edge ticks allow slack
		for (int i = 0; i < 4; i++) begin
			wr(OFF_CNT_LOW, 8'h00);
			wr(OFF_CONTROL, 8'(8'h44 + i));
			repeat (320) @(posedge aclk);
			wr(OFF_CONTROL, 8'h40);
			rd(OFF_CNT_LOW, 8'(320 / divs[i] - 1), 8'(328 / divs[i] + 1));
		end
		$display("test prescaler done");
		repeat (3) @(posedge aclk);
		close_out();
	end
endmodule
bind dmct_timer dmct_sva sva_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .power_mode(power_mode),
	.compare_out_high(compare_out_high), .compare_out_low(compare_out_low));
